// *** bench/dla_autobaud_tb.sv ***
// self-checking bench for the auto-baud detector
// assumes host model and checker compiled first
`timescale 1ns/1ps
`define CHK(a,b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
`define WT(c) begin k = 0; while (!(c) && k < 9000) begin @(negedge clock); k++; end \
  if (k == 9000) begin err_count++; stop_test(); end end
module dla_autobaud_tb;
  typedef struct { int n; logic s; logic [9:0] p; } dla_row_s;
  logic       clock = 0, rstn = 0, frame_err = 0, tx_collide = 0, host_low;
  logic       ce = 1;
  logic       line_in, line_oe, line_out, synced, bit_tick, link_reset, cmd_abort;
  logic [9:0] bit_period;
  int         err_count = 0, total_checks = 0, k;
  dla_row_s   rows [5] = '{'{20,0,0}, '{34,1,4}, '{100,1,12}, '{4092,1,511}, '{4200,0,0}};
  always #12.5 clock = ~clock;
  assign line_in = !(host_low || line_oe); // pull-up wins when nobody pulls
  dla_host dla_host_inst (.clk(clock), .pull_low(host_low));
  dla_autobaud dla_autobaud_inst (.CLOCK(clock), .RSTN(rstn), .CE(ce),
    .DEBUG_SERIAL_LINE_IN(line_in), .DEBUG_SERIAL_LINE_OUT(line_out),
    .DEBUG_SERIAL_LINE_OE(line_oe), .FRAME_ERR(frame_err), .TX_COLLIDE(tx_collide),
    .SYNCED(synced), .BIT_PERIOD(bit_period), .BIT_TICK(bit_tick),
    .LINK_RESET(link_reset), .CMD_ABORT(cmd_abort));
  task automatic stop_test();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // reset, then sync with an n-cycle low pulse
  task automatic sync(input int n);
    @(posedge clock) rstn <= 1'b0;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    dla_host_inst.low(n);
    repeat (4) @(negedge clock);
  endtask : sync
  initial begin
    repeat (100000) @(posedge clock);
    err_count++;
    stop_test();
  end
  initial begin
    foreach (rows[i]) begin
      sync(rows[i].n);
      `CHK({synced, bit_period}, {rows[i].s, rows[i].p})
    end
    sync(100);
    `WT(bit_tick)
    @(negedge clock);
    `WT(bit_tick)
    `CHK(k + 1, 12)
    // clock enable low freezes everything, ticks included
    @(posedge clock) ce <= 1'b0;
    repeat (30) @(negedge clock);
    `CHK({synced, bit_period, bit_tick, line_out}, 13'h1030)
    @(posedge clock) ce <= 1'b1;
    @(posedge clock);
    fork
      dla_host_inst.low(112);
      `WT(link_reset)
    join
    `CHK(k >= 106 && k <= 112, 1'b1)
    repeat (4) @(negedge clock);
    `CHK({synced, bit_period}, 11'h0)
    // both fault sources, each from a fresh sync
    for (int j = 0; j < 2; j++) begin
      sync(100);
      @(posedge clock) {tx_collide, frame_err} <= j ? 2'h2 : 2'h1;
      @(posedge clock) {tx_collide, frame_err} <= 2'h0;
      `WT(cmd_abort)
      `CHK(link_reset, 1'b1)
      `WT(line_oe)
      `WT(!line_oe)
      `CHK(k >= 476 && k <= 484, 1'b1)
    end
    @(posedge clock) frame_err <= 1'b1;
    @(posedge clock) frame_err <= 1'b0;
    repeat (3) @(negedge clock);
    `CHK({cmd_abort, line_oe}, 2'h0)
    stop_test();
  end
endmodule : dla_autobaud_tb

// *** bench/dla_checker.sv ***
// checker for the auto-baud block, watching top ports only
// assumes one clock domain; bound at the foot of this file
`timescale 1ns/1ps
module dla_checker #(
  parameter int CW = 13
) (
  input wire logic          CLOCK,
  input wire logic          RSTN,
  input wire logic          DEBUG_SERIAL_LINE_IN,
  input wire logic          DEBUG_SERIAL_LINE_OE,
  input wire logic          FRAME_ERR,
  input wire logic          TX_COLLIDE,
  input wire logic          SYNCED,
  input wire logic [CW-4:0] BIT_PERIOD,
  input wire logic          BIT_TICK,
  input wire logic          LINK_RESET,
  input wire logic          CMD_ABORT
);
  logic [15:0] lowc_r;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // run length of the low line, for the break bound
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) lowc_r <= 16'h0;
    else lowc_r <= DEBUG_SERIAL_LINE_IN ? 16'h0 : lowc_r + 16'h1;
  end
  AST_SYNC_LINE: assert property ($rose(SYNCED) |->
    DEBUG_SERIAL_LINE_IN && !DEBUG_SERIAL_LINE_OE)
    else $error("sync without line release");
  AST_PERIOD_MIN: assert property (SYNCED |-> BIT_PERIOD >= 4)
    else $error("bit period below four");
  AST_PERIOD_HOLD: assert property (SYNCED && $past(SYNCED) |-> $stable(BIT_PERIOD))
    else $error("bit period moved while synced");
  AST_TICK_SYNC: assert property (BIT_TICK |-> SYNCED || $past(SYNCED))
    else $error("tick while unsynced");
  AST_TICK_GAP: assert property (BIT_TICK |=> !BIT_TICK [*3])
    else $error("ticks closer than four clocks");
  AST_BREAK_BOUND: assert property (SYNCED |-> lowc_r <= 9 * BIT_PERIOD + 3)
    else $error("break not taken in time");
  AST_LINK_DROP: assert property (LINK_RESET |-> ##[0:1] !SYNCED)
    else $error("sync kept after link reset");
  AST_ABORT_CAUSE: assert property (CMD_ABORT |-> $past(SYNCED && (FRAME_ERR || TX_COLLIDE)))
    else $error("abort without cause");
  AST_ABORT_BREAK: assert property (CMD_ABORT |-> LINK_RESET ##[1:4] DEBUG_SERIAL_LINE_OE)
    else $error("no answering break");
  AST_OE_UNSYNC: assert property ($rose(DEBUG_SERIAL_LINE_OE) |-> !SYNCED)
    else $error("break sent while synced");
endmodule : dla_checker
bind dla_autobaud dla_checker #(.CW(CW)) dla_checker_inst (.CLOCK, .RSTN,
  .DEBUG_SERIAL_LINE_IN, .DEBUG_SERIAL_LINE_OE,
  .FRAME_ERR, .TX_COLLIDE, .SYNCED, .BIT_PERIOD, .BIT_TICK, .LINK_RESET, .CMD_ABORT);

// *** bench/dla_host.sv ***
// host model: pulls the open-drain debug line low on request
// assumes the bench resolves the wire with a pull-up
`timescale 1ns/1ps
module dla_host (
  input  wire logic clk,
  output logic      pull_low
);
  initial pull_low = 1'b0;
  // low n cycles then release; any n, even faster than clock over four
  task automatic low(input int n);
    pull_low <= 1'b1;
    repeat (n) @(posedge clk);
    pull_low <= 1'b0;
  endtask : low
endmodule : dla_host

// *** hdl/dla_autobaud.sv ***
// auto-baud detector, bit-time generator and error break sender
// for the single-wire debug serial line of the debug unit
// assumes the line input is already synchronous to CLOCK
// assumes the pin is open drain with a pull-up outside the block
`timescale 1ns/1ps
module dla_autobaud
  import dla_pkg::*;
#(
  parameter int CW = 13 // measurement counter width
) (
  input  wire logic          CLOCK,
  input  wire logic          RSTN,
  input  wire logic          CE,
  input  wire logic          DEBUG_SERIAL_LINE_IN,
  output logic               DEBUG_SERIAL_LINE_OUT,
  output logic               DEBUG_SERIAL_LINE_OE,
  input  wire logic          FRAME_ERR,
  input  wire logic          TX_COLLIDE,
  output logic               SYNCED,
  output logic [CW-4:0]      BIT_PERIOD,
  output logic               BIT_TICK,
  output logic               LINK_RESET,
  output logic               CMD_ABORT
);
  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  // counter must hold the slowest sync character and a whole break
  if ((1 << CW) <= MAX_DIV * BREAK_BITS + MAX_DIV) begin : g_cw_small
    $error("dla_autobaud: CW too small for slowest baud rate");
  end
  // period must at least hold the fastest legal bit time
  if (CW - SYNC_SHIFT < SYNC_SHIFT) begin : g_pw_small
    $error("dla_autobaud: CW too small for bit period");
  end

  localparam int PW = CW - SYNC_SHIFT;

  // ------------------------------------------------------------------
  // state and helpers
  // ------------------------------------------------------------------
  dla_state_e    state_r;
  logic [CW-1:0] meas_r;
  logic [PW-1:0] period_r;
  logic [CW-1:0] low_cnt_r;
  logic          line_prev_r;
  logic          brk_req_r;
  logic [5:0]    brk_bits_r;
  logic          tick;

  // a low run of nine bit times ends the link
  function automatic logic break_seen(input logic          line,
                                      input logic [CW-1:0] run_len,
                                      input logic [CW-1:0] limit);
    break_seen = !line && (run_len >= limit);
  endfunction : break_seen

  // history resets high, the idle level, so no false edge follows reset
  wire fall       = line_prev_r & ~DEBUG_SERIAL_LINE_IN;
  wire rise       = ~line_prev_r & DEBUG_SERIAL_LINE_IN;
  wire err_event  = (FRAME_ERR | TX_COLLIDE) & (state_r == DLA_SYNC);
  // nine bit times of low is eight-bit count times nine over eight
  wire [CW-1:0] brk_lim = CW'(period_r) * CW'(BREAK_BITS);
  wire          brk_hit = break_seen(DEBUG_SERIAL_LINE_IN, low_cnt_r, brk_lim);
  // the generator restarts on an error so the answering break is whole
  wire          gen_run = ((state_r == DLA_SYNC) && !err_event) || brk_req_r;

  // ------------------------------------------------------------------
  // line edge history
  // ------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) line_prev_r <= 1'b1;
    else if (CE) line_prev_r <= DEBUG_SERIAL_LINE_IN;
  end

  // ------------------------------------------------------------------
  // detector state machine
  // ------------------------------------------------------------------
  // only a falling edge leaves idle; all else ignored
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_r  <= DLA_IDLE;
      meas_r   <= '0;
      period_r <= '0;
    end else if (CE) begin
      case (state_r)
        DLA_IDLE: begin
          // the falling-edge clock is already one low cycle
          if (fall) begin
            state_r <= DLA_MEAS;
            meas_r  <= CW'(1);
          end else begin
            meas_r  <= '0;
          end
        end
        DLA_MEAS: begin
          // count low time in system clocks
          if (rise) begin
            // too short to be legal at clock over four: drop it
            if (meas_r < CW'(MIN_DIV * SYNC_BITS)) begin
              state_r <= DLA_IDLE;
            end else if (meas_r > CW'(MAX_DIV * SYNC_BITS)) begin
              state_r <= DLA_IDLE;
            end else begin
              period_r <= meas_r[CW-1:SYNC_SHIFT];
              state_r  <= DLA_SYNC;
            end
          end else if (meas_r != '1) begin
            meas_r <= meas_r + CW'(1);
          end
        end
        DLA_SYNC: begin
          // break from host or local error drops sync
          if (err_event || brk_hit) begin
            state_r  <= DLA_BREAK;
          end
        end
        DLA_BREAK: begin
          // wait for our break to end and the line to rise
          if (!brk_req_r && DEBUG_SERIAL_LINE_IN) begin
            state_r  <= DLA_IDLE;
            period_r <= '0;
          end
        end
        default: state_r <= DLA_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // low run length while synchronised
  // ------------------------------------------------------------------
  // saturates rather than wraps so a very long break still counts
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) low_cnt_r <= '0;
    else if (CE) begin
      if (DEBUG_SERIAL_LINE_IN || state_r != DLA_SYNC) low_cnt_r <= '0;
      else if (low_cnt_r != '1) low_cnt_r <= low_cnt_r + CW'(1);
    end
  end

  // ------------------------------------------------------------------
  // answering break: four characters of low
  // ------------------------------------------------------------------
  // open drain lets this only lengthen a host break
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      brk_req_r  <= 1'b0;
      brk_bits_r <= '0;
    end else if (CE) begin
      if (err_event && !brk_req_r) begin
        brk_req_r  <= 1'b1;
        brk_bits_r <= 6'(TX_BREAK_CHARS * CHAR_BITS);
      end else if (brk_req_r && tick) begin
        if (brk_bits_r <= 6'd1) brk_req_r <= 1'b0;
        brk_bits_r <= brk_bits_r - 6'd1;
      end
    end
  end

  // ------------------------------------------------------------------
  // bit-time generator
  // ------------------------------------------------------------------
  // one period serves receive sampling and transmit timing
  dla_baud_gen #(.CW(PW)) u_gen (
    .clk    (CLOCK),
    .rst_n  (RSTN),
    .ce     (CE),
    .run    (gen_run),
    .period (period_r),
    .tick   (tick)
  );

  // ------------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------------
  // never drives unless a break is owed after sync
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      DEBUG_SERIAL_LINE_OUT <= 1'b1;
      DEBUG_SERIAL_LINE_OE  <= 1'b0;
      SYNCED     <= 1'b0;
      BIT_PERIOD <= '0;
      BIT_TICK   <= 1'b0;
      LINK_RESET <= 1'b0;
      CMD_ABORT  <= 1'b0;
    end else if (CE) begin
      // open drain: data is always low, the enable does the work
      DEBUG_SERIAL_LINE_OUT <= 1'b0;
      DEBUG_SERIAL_LINE_OE  <= brk_req_r;
      SYNCED     <= (state_r == DLA_SYNC);
      BIT_PERIOD <= period_r;
      BIT_TICK   <= tick & (state_r == DLA_SYNC);
      LINK_RESET <= (state_r == DLA_SYNC) && (err_event || brk_hit);
      CMD_ABORT  <= err_event;
    end
  end
endmodule : dla_autobaud

// *** hdl/dla_baud_gen.sv ***
// baud tick generator: pulses once each programmed bit period
// assumes period is steady while run is high
`timescale 1ns/1ps
module dla_baud_gen #(
  parameter int CW = 13
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire logic          run,
  input  wire logic [CW-1:0] period,
  output logic               tick
);
  logic [CW-1:0] cnt_r;

  // ------------------------------------------------------------------
  // counter
  // ------------------------------------------------------------------
  // restarts on every idle so phase follows the caller
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (!run) begin
        cnt_r <= '0;
      end else if (cnt_r + CW'(1) >= period) begin
        cnt_r <= '0;
        tick  <= 1'b1;
      end else begin
        cnt_r <= cnt_r + CW'(1);
      end
    end
  end
endmodule : dla_baud_gen

// *** hdl/dla_pkg.sv ***
// constants for the debug link auto-baud detector and generator
// assumes a single system clock; the debug serial line is open drain
//
// What this block does
// - host syncs with 80H, eight low bits
// - measure low period, load baud generator
// - detector and generator run on system clock
// - counter holds 512-cycle bit times
// - absolute limit is clock over four
// - nine low bit times is a break
// - framing error or collision sends four-character break
// - break resets baud logic, not control register
package dla_pkg;
  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int SYNC_BITS      = 8;   // low bit times in 80H
  localparam int SYNC_SHIFT     = 3;   // divide by eight
  localparam int BREAK_BITS     = 9;   // low bit times that make a break
  localparam int MIN_DIV        = 4;   // fastest link: clock over four
  localparam int MAX_DIV        = 512; // slowest link: clock over 512
  localparam int CHAR_BITS      = 10;  // start, eight data, stop
  localparam int TX_BREAK_CHARS = 4;   // length of the answering break
  localparam int BYTE_W         = 8;
  localparam logic [7:0] SYNC_CHAR = 8'h80;

  // detector states, one-hot
  typedef enum logic [3:0] {
    DLA_IDLE  = 4'h1,
    DLA_MEAS  = 4'h2,
    DLA_SYNC  = 4'h4,
    DLA_BREAK = 4'h8
  } dla_state_e;
endpackage : dla_pkg
